// *** dv/rgs_rx_chain_model.sv ***
// comparator side of the analog receive chain, noise on request
module rgs_rx_chain_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // bench control: one noise enable per comparator
  input  wire logic [3:0] noiseSel,
  // comparator outputs
  output logic            digitizerOut,
  output logic            squelchCompare6,
  output logic            agcCompare3,
  output logic            agcCompare6
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q;
  logic [3:0] out_q;
  // a toggle every third cycle gives several edges per squelch window
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 2'h0;
      out_q <= 4'h0;
    end else begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      if (div_q == 2'h2) begin
        out_q <= out_q ^ noiseSel;
      end
    end
  end
  // a quiet comparator holds its last level, as a real one does
  assign digitizerOut    = out_q[0];
  assign squelchCompare6 = out_q[1];
  assign agcCompare3     = out_q[2];
  assign agcCompare6     = out_q[3];
endmodule : rgs_rx_chain_model

// *** dv/rx_gain_squelch_rssi_control_tb_top.sv ***
// self-checking bench for the receive gain control
module rx_gain_squelch_rssi_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic [7:0]               regAddr = 8'h00;
  logic [7:0]               regWdata = 8'h00;
  logic                     regWrite = 1'b0;
  logic                     regRead = 1'b0;
  logic [7:0]               regRdata;
  logic                     rxOn = 1'b0;
  logic                     txEnd = 1'b0;
  logic [7:0]               mask_receive_timer = 8'h20;
  logic [1:0][3:0]          level = '0;
  logic [3:0]               noise = 4'h0;
  logic                     dig;
  logic                     sq6;
  logic                     agc3;
  logic                     agc6;
  rgs_pkg::rgs_rx_ctrl_type rxCtrl;
  logic [7:0]               expQ[$];
  logic                     readSeen = 1'b0;
  logic                     boostE = 1'b0;
  logic [2:0]               firstE = 3'h6;
  logic [7:0]               filtE = 8'h00;
  logic [7:0]               v;
  integer                   seed = 22;
  int                       n_errors = 0;
  int                       n_compared = 0;

  always #5 clk = ~clk;

  // short window keeps squelch runs brief
  rgs_rx_gain_ctrl #(.WINDOW_CYCLES(20)) DUT (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .rxOn(rxOn), .txEnd(txEnd), .maskReceiveTimer(mask_receive_timer),
    .digitizerOut(dig), .squelchCompare6(sq6), .agcCompare3(agc3),
    .agcCompare6(agc6), .strengthLevel(level), .rxCtrl(rxCtrl));

  rgs_rx_chain_model PART (
    .clk(clk), .rst(rst), .noiseSel(noise), .digitizerOut(dig),
    .squelchCompare6(sq6), .agcCompare3(agc3), .agcCompare6(agc6));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
  endtask : rd

  task automatic cmpReg(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t reg got %h exp %h", $time, g, e);
    end
  endtask : cmpReg

  // read data stand only in the cycle after the strobe
  always @(posedge clk) readSeen <= regRead;
  always @(negedge clk) begin
    if (readSeen) begin
      cmpReg(regRdata, expQ.pop_front());
    end
  end

  function automatic rgs_pkg::rgs_rx_ctrl_type expCtl(input logic [3:0] s);
    logic [3:0] t;
    t = s - 4'h4;
    expCtl = (s > 4'h4) ? {boostE, firstE, filtE, t[2:0], 3'h4}
                        : {boostE, firstE, filtE, 3'h0, s[2:0]};
  endfunction : expCtl

  // rxCtrl lags register writes and gain steps, so let it settle
  task automatic cmpCtl(input logic [3:0] s);
    rgs_pkg::rgs_rx_ctrl_type e;
    e = expCtl(s);
    cyc(2);
    @(negedge clk);
    n_compared++;
    if (rxCtrl !== e) begin
      n_errors++;
      $display("BAD %0t ctl got %h exp %h", $time, rxCtrl, e);
    end
  endtask : cmpCtl

  task automatic cmdReset(input logic [3:0] m);
    wr(8'h03, {4'h0, m});
    wr(8'h07, 8'h01);
  endtask : cmdReset

  task automatic agcRun(input logic [7:0] cfg, input logic [3:0] pre,
                        input logic [3:0] nz, input logic [3:0] s);
    cmdReset(4'h0);
    wr(8'h02, cfg);
    rxOn  <= 1'b1;
    noise <= pre;
    cyc(60);
    noise <= nz;
    cyc(60);
    noise <= 4'h0;
    cmpCtl(s);
    @(posedge clk);
    rxOn <= 1'b0;
    cmpCtl(4'h0);
    rd(8'h05, {4'h0, s});
    $display("test agc %h done", cfg);
  endtask : agcRun

  task automatic sqRun(input logic [7:0] cfg, input logic [7:0] tmr,
                       input logic [3:0] nz, input logic [3:0] s);
    cmdReset(4'h0);
    wr(8'h02, cfg);
    wr(8'h04, tmr);
    noise <= nz;
    txEnd <= 1'b1;
    @(posedge clk);
    txEnd <= 1'b0;
    cyc(1850);
    cmpCtl(4'h0);
    cyc(400);
    noise <= 4'h0;
    cmpCtl(s);
    $display("test squelch %h done", cfg);
  endtask : sqRun

  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    cyc(3);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(8'(i), (i == 1) ? 8'h06 : 8'h00);
    end
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h00);
    repeat (4) begin
      v = 8'($random(seed));
      filtE = v;
      wr(8'h00, v);
      rd(8'h00, v);
      cmpCtl(4'h0);
    end
    boostE = 1'b1;
    wr(8'h01, 8'h0f);
    rd(8'h01, 8'h0e);
    cmpCtl(4'h0);
    firstE = 3'h3;
    wr(8'h01, 8'h0b);
    cmpCtl(4'h0);
    wr(8'h03, 8'h0f);
    rd(8'h03, 8'h0a);
    for (int s = 0; s < 11; s++) begin
      cmdReset(4'(s));
      cmpCtl(4'(s));
    end
    $display("test registers done");
    agcRun(8'h04, 4'h0, 4'h4, 4'ha);
    agcRun(8'h24, 4'h0, 4'h4, 4'h0);
    agcRun(8'h24, 4'h0, 4'h8, 4'ha);
    agcRun(8'h00, 4'h0, 4'h4, 4'h0);
    agcRun(8'h0c, 4'h1, 4'h4, 4'h0);
    agcRun(8'h04, 4'h1, 4'h4, 4'ha);
    agcRun(8'h14, 4'h0, 4'h0, 4'h4);
    // strength: peak, cleared on each gain loop step, frozen when idle
    cmdReset(4'h0);
    wr(8'h02, 8'h04);
    level <= {4'hf, 4'h9};
    rxOn  <= 1'b1;
    cyc(5);
    rd(8'h06, 8'hd9);
    level <= {4'h3, 4'h2};
    noise <= 4'h4;
    cyc(60);
    noise <= 4'h0;
    cyc(5);
    rd(8'h06, 8'h32);
    rxOn  <= 1'b0;
    level <= {4'hf, 4'hf};
    cyc(3);
    rd(8'h06, 8'h32);
    wr(8'h07, 8'h02);
    cyc(2);
    rd(8'h06, 8'h00);
    $display("test strength done");
    sqRun(8'h01, 8'hff, 4'h1, 4'ha);
    cmdReset(4'h2);
    cmpCtl(4'h2);
    sqRun(8'h03, 8'hff, 4'h1, 4'h0);
    sqRun(8'h03, 8'hff, 4'h2, 4'ha);
    sqRun(8'h01, 8'h20, 4'h1, 4'h0);
    sqRun(8'h00, 8'hff, 4'h1, 4'h0);
    print_verdict();
  end

  // whole run is about 12.5k cycles
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end
endmodule : rx_gain_squelch_rssi_control_tb_top

// *** rtl/rgs_pkg.sv ***
// constants, field layouts and carrier types for the receive gain control
package rgs_pkg;
  // register offsets
  localparam logic [7:0] ADDR_FILTER    = 8'h00;
  localparam logic [7:0] ADDR_FIRST     = 8'h01;
  localparam logic [7:0] ADDR_LOOP      = 8'h02;
  localparam logic [7:0] ADDR_MANUAL    = 8'h03;
  localparam logic [7:0] ADDR_SQTIMER   = 8'h04;
  localparam logic [7:0] ADDR_GAINSTATE = 8'h05;
  localparam logic [7:0] ADDR_STRENGTH  = 8'h06;
  localparam logic [7:0] ADDR_CMD       = 8'h07;
  // reset values
  localparam logic [7:0] FILTER_RST     = 8'h00;
  localparam logic [3:0] FIRST_RST      = 4'h6;
  localparam logic [7:0] LOOP_RST       = 8'h00;
  localparam logic [3:0] MANUAL_RST     = 4'h0;
  localparam logic [7:0] SQTIMER_RST    = 8'h00;
  // field positions
  localparam int CMD_RESET_GAIN_BIT     = 0;
  localparam int CMD_STRENGTH_CLEAR_BIT = 1;
  localparam int FIRST_BOOST_BIT        = 3;
  // step limits
  localparam logic [3:0] GAIN_LAST      = 4'ha;
  localparam logic [3:0] WINDOW_STEPS   = 4'h4;
  localparam logic [2:0] FIRST_RED_MAX  = 3'h6;
  localparam logic [3:0] STRENGTH_MAX   = 4'hd;
  localparam logic [3:0] PULSE_LIMIT    = 4'h8;
  localparam logic [1:0] SQ_TRANS_LIMIT = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SQ_DELAY_NS   = 18880;
  localparam int SQ_DELAY_CYC  =
    (SQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WINDOW_US     = 50;
  localparam int WINDOW_CYC    = (WINDOW_US * 1000) / CLK_PERIOD_NS;

  typedef struct packed {
    logic       spare;
    logic [2:0] lowpassCorner;
    logic       firstZeroHighSelect;
    logic       thirdZeroMidSelect;
    logic       thirdZeroLowSelect;
    logic       firstZeroLowSelect;
  } rgs_filter_type;

  typedef struct packed {
    logic [1:0] spare;
    logic       gainLoopRatioSelect;
    logic       agcAlgPreset;
    logic       agcModeFirst8;
    logic       agcEnable;
    logic       squelchRatioSix;
    logic       squelchDynamic;
  } rgs_loop_cfg_type;

  typedef struct packed {
    logic           boost;
    logic [2:0]     firstStageRed;
    rgs_filter_type filter;
    logic [2:0]     stageRed;
    logic [2:0]     windowStep;
  } rgs_rx_ctrl_type;

  typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_OBSERVE} rgs_sq_state_type;
endpackage : rgs_pkg

// *** rtl/rgs_rx_gain_ctrl.sv ***
// receive gain, squelch and signal strength control
// Functional notes
// R1 - first stage six 2.5 dB cuts, boost option
// R2 - three-bit low-pass corner select field
// R3 - four shared bits pick both zeros
// R4 - stage gain 23 dB, six 3 dB cuts
// R5 - reset gain command reloads manual setting
// R6 - five digitizer window settings, 3 dB apart
// R7 - eleven steps: four window, six gain
// R8 - capture gain state on receiver-on fall
// R9 - gain loop runs only while receiving
// R10 - squelch from delay after TX to timer
// R11 - ratio bit picks squelch comparator
// R12 - over two transitions per window: step
// R13 - ratio six counts wide comparator edges
// R14 - gain loop steps on comparator transitions
// R15 - mode bit limits loop to eight pulses
// R16 - algorithm bit picks preset or reset start
// R17 - strength tracks while receiving, else frozen
// R18 - peak hold, cleared on gain loop step
// R19 - four-bit code, saturates at thirteen
// R20 - clear command zeros signal strength
// R21 - gain state saturates at last step
module rgs_rx_gain_ctrl #(
  parameter int WINDOW_CYCLES = rgs_pkg::WINDOW_CYC
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // register port
  input  wire logic [7:0]               regAddr,
  input  wire logic [7:0]               regWdata,
  input  wire logic                     regWrite,
  input  wire logic                     regRead,
  output logic      [7:0]               regRdata,
  // receive chain observation
  input  wire logic                     rxOn,
  input  wire logic                     txEnd,
  input  wire logic [7:0]               maskReceiveTimer,
  input  wire logic                     digitizerOut,
  input  wire logic                     squelchCompare6,
  input  wire logic                     agcCompare3,
  input  wire logic                     agcCompare6,
  input  wire logic [1:0][3:0]          strengthLevel,
  // analog settings
  output rgs_pkg::rgs_rx_ctrl_type      rxCtrl
);
  localparam logic [15:0] WIN_LAST = 16'(WINDOW_CYCLES - 1);
  localparam logic [10:0] DLY_LAST = 11'(rgs_pkg::SQ_DELAY_CYC - 1);
  localparam int          DLY_LAST_I = rgs_pkg::SQ_DELAY_CYC - 1;
  default clocking asrtClk @(posedge clk); endclocking
  default disable iff (rst);

  // software registers
  rgs_pkg::rgs_filter_type   filter_q, filter_d;
  rgs_pkg::rgs_loop_cfg_type cfg_q, cfg_d;
  logic [3:0] first_q, first_d;
  logic [3:0] manual_q, manual_d;
  logic [7:0] sqTimer_q, sqTimer_d;
  logic [7:0] rdata_q, rdata_d;
  logic       cmdResetGain;
  logic       cmdClear;
  // gain state
  logic [3:0] gainState_q, gainState_d;
  logic [3:0] squelchLevel_q, squelchLevel_d;
  logic [3:0] capture_q, capture_d;
  logic [3:0] pulseCnt_q, pulseCnt_d;
  logic       agcStep;
  logic       sqStep;
  // previous input samples for edge detection
  logic       rxOnPrev_q, digPrev_q, sqCmpPrev_q, agcPrev_q;
  logic       agcSel, sqSel, sqTrans, agcTrans, digRise;
  // squelch
  rgs_pkg::rgs_sq_state_type sqState_q, sqState_d;
  logic [10:0] delayCnt_q, delayCnt_d;
  logic [15:0] winCnt_q, winCnt_d;
  logic [1:0]  transCnt_q, transCnt_d;
  logic        sqStop;
  // strength
  logic [1:0][3:0] strength_q;
  logic            clrStrength;
  rgs_pkg::rgs_rx_ctrl_type ctrl_q, ctrl_d;

  assign cmdResetGain = regWrite && regAddr == rgs_pkg::ADDR_CMD &&
                        regWdata[rgs_pkg::CMD_RESET_GAIN_BIT];
  assign cmdClear     = regWrite && regAddr == rgs_pkg::ADDR_CMD &&
                        regWdata[rgs_pkg::CMD_STRENGTH_CLEAR_BIT];

  always_comb begin
    filter_d  = filter_q;
    cfg_d     = cfg_q;
    first_d   = first_q;
    manual_d  = manual_q;
    sqTimer_d = sqTimer_q;
    rdata_d   = 8'h00;
    if (regWrite) begin
      unique case (regAddr)
        rgs_pkg::ADDR_FILTER:  filter_d = regWdata; // R2 R3
        rgs_pkg::ADDR_FIRST: begin
          // cuts past the sixth step would exceed the range
          first_d = {regWdata[rgs_pkg::FIRST_BOOST_BIT],
                     (regWdata[2:0] > rgs_pkg::FIRST_RED_MAX) ?
                     rgs_pkg::FIRST_RED_MAX : regWdata[2:0]}; // R1
        end
        rgs_pkg::ADDR_LOOP:    cfg_d = regWdata;
        rgs_pkg::ADDR_MANUAL: begin
          manual_d = (regWdata[3:0] > rgs_pkg::GAIN_LAST) ?
                     rgs_pkg::GAIN_LAST : regWdata[3:0]; // R21
        end
        rgs_pkg::ADDR_SQTIMER: sqTimer_d = regWdata;
        default: ;
      endcase
    end
    if (regRead) begin
      unique case (regAddr)
        rgs_pkg::ADDR_FILTER:    rdata_d = filter_q;
        rgs_pkg::ADDR_FIRST:     rdata_d = {4'h0, first_q};
        rgs_pkg::ADDR_LOOP:      rdata_d = cfg_q;
        rgs_pkg::ADDR_MANUAL:    rdata_d = {4'h0, manual_q};
        rgs_pkg::ADDR_SQTIMER:   rdata_d = sqTimer_q;
        rgs_pkg::ADDR_GAINSTATE: rdata_d = {4'h0, capture_q}; // R8
        rgs_pkg::ADDR_STRENGTH:  rdata_d = strength_q; // R19
        default:                 rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filter_q  <= rgs_pkg::FILTER_RST;
      cfg_q     <= rgs_pkg::LOOP_RST;
      first_q   <= rgs_pkg::FIRST_RST;
      manual_q  <= rgs_pkg::MANUAL_RST;
      sqTimer_q <= rgs_pkg::SQTIMER_RST;
      rdata_q   <= 8'h00;
    end else begin
      filter_q  <= filter_d;
      cfg_q     <= cfg_d;
      first_q   <= first_d;
      manual_q  <= manual_d;
      sqTimer_q <= sqTimer_d;
      rdata_q   <= rdata_d;
    end
  end
  assign regRdata = rdata_q;

  // comparator selection and edges
  assign sqSel    = cfg_q.squelchRatioSix ? squelchCompare6 : digitizerOut;
  assign agcSel   = cfg_q.gainLoopRatioSelect ? agcCompare6 : agcCompare3;
  assign sqTrans  = sqSel ^ sqCmpPrev_q; // R11 R13
  assign agcTrans = agcSel ^ agcPrev_q; // R14
  assign digRise  = digitizerOut && !digPrev_q;
  assign sqStop   = maskReceiveTimer == sqTimer_q; // R10

  always_ff @(posedge clk) begin
    if (rst) begin
      rxOnPrev_q  <= 1'b0;
      digPrev_q   <= 1'b0;
      sqCmpPrev_q <= 1'b0;
      agcPrev_q   <= 1'b0;
    end else begin
      rxOnPrev_q  <= rxOn;
      digPrev_q   <= digitizerOut;
      sqCmpPrev_q <= sqSel;
      agcPrev_q   <= agcSel;
    end
  end

  // squelch observation windows
  always_comb begin
    sqState_d  = sqState_q;
    delayCnt_d = delayCnt_q;
    winCnt_d   = winCnt_q;
    transCnt_d = transCnt_q;
    sqStep     = 1'b0;
    unique case (sqState_q)
      rgs_pkg::SQ_IDLE: begin
        if (txEnd && cfg_q.squelchDynamic) begin
          sqState_d  = rgs_pkg::SQ_WAIT; // R10
          delayCnt_d = 11'h000;
        end
      end
      rgs_pkg::SQ_WAIT: begin
        if (sqStop) begin
          sqState_d = rgs_pkg::SQ_IDLE;
        end else if (delayCnt_q == DLY_LAST) begin
          sqState_d  = rgs_pkg::SQ_OBSERVE; // R10
          winCnt_d   = 16'h0000;
          transCnt_d = 2'h0;
        end else begin
          delayCnt_d = delayCnt_q + 11'h001;
        end
      end
      rgs_pkg::SQ_OBSERVE: begin
        if (sqTrans && transCnt_q != 2'h3) begin
          transCnt_d = transCnt_q + 2'h1;
        end
        if (sqStop) begin
          sqState_d = rgs_pkg::SQ_IDLE; // R10
        end else if (winCnt_q == WIN_LAST) begin
          winCnt_d   = 16'h0000;
          if (transCnt_d > rgs_pkg::SQ_TRANS_LIMIT &&
              squelchLevel_q < rgs_pkg::GAIN_LAST) begin
            sqStep = 1'b1; // R12 R21
          end else begin
            sqState_d = rgs_pkg::SQ_IDLE; // R12
          end
          transCnt_d = 2'h0;
        end else begin
          winCnt_d = winCnt_q + 16'h0001;
        end
      end
    endcase
    if (cmdResetGain || !cfg_q.squelchDynamic) begin
      sqState_d = rgs_pkg::SQ_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sqState_q  <= rgs_pkg::SQ_IDLE;
      delayCnt_q <= 11'h000;
      winCnt_q   <= 16'h0000;
      transCnt_q <= 2'h0;
    end else begin
      sqState_q  <= sqState_d;
      delayCnt_q <= delayCnt_d;
      winCnt_q   <= winCnt_d;
      transCnt_q <= transCnt_d;
    end
  end

  // shared gain reduction state
  always_comb begin
    gainState_d    = gainState_q;
    squelchLevel_d = squelchLevel_q;
    capture_d      = capture_q;
    pulseCnt_d     = pulseCnt_q;
    agcStep        = 1'b0;
    if (rxOnPrev_q && !rxOn) begin
      capture_d = gainState_q; // R8
    end
    if (cmdResetGain) begin
      squelchLevel_d = manual_q; // R5
      gainState_d    = manual_q; // R5
      pulseCnt_d     = 4'h0;
    end else begin
      if (sqStep) begin
        squelchLevel_d = squelchLevel_q + 4'h1; // R12
      end
      if (!rxOn) begin
        gainState_d = squelchLevel_d; // R9
        pulseCnt_d  = 4'h0;
      end else if (!rxOnPrev_q) begin
        // preset start skips the window steps for short frames
        gainState_d = (cfg_q.agcAlgPreset &&
                       squelchLevel_d < rgs_pkg::WINDOW_STEPS) ?
                      rgs_pkg::WINDOW_STEPS : squelchLevel_d; // R16
      end else begin
        if (digRise && pulseCnt_q < rgs_pkg::PULSE_LIMIT) begin
          pulseCnt_d = pulseCnt_q + 4'h1;
        end
        if (cfg_q.agcEnable && agcTrans &&
            (!cfg_q.agcModeFirst8 || pulseCnt_q < rgs_pkg::PULSE_LIMIT) &&
            gainState_q < rgs_pkg::GAIN_LAST) begin
          agcStep = 1'b1; // R14 R15
        end
        if ((agcStep || sqStep) && gainState_q < rgs_pkg::GAIN_LAST) begin
          gainState_d = gainState_q + 4'h1; // R21
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gainState_q    <= rgs_pkg::MANUAL_RST;
      squelchLevel_q <= rgs_pkg::MANUAL_RST;
      capture_q      <= rgs_pkg::MANUAL_RST;
      pulseCnt_q     <= 4'h0;
    end else begin
      gainState_q    <= gainState_d;
      squelchLevel_q <= squelchLevel_d;
      capture_q      <= capture_d;
      pulseCnt_q     <= pulseCnt_d;
    end
  end

  // per-channel peak hold
  assign clrStrength = cmdResetGain || cmdClear || agcStep; // R18 R20
  for (genvar ch = 0; ch < 2; ch++) begin : g_strength
    logic [3:0] held_d;
    always_comb begin
      held_d = strength_q[ch];
      if (clrStrength) begin
        held_d = 4'h0; // R18 R20
      end else if (rxOn && strengthLevel[ch] > strength_q[ch]) begin
        held_d = (strengthLevel[ch] > rgs_pkg::STRENGTH_MAX) ?
                 rgs_pkg::STRENGTH_MAX : strengthLevel[ch]; // R17 R19
      end
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        strength_q[ch] <= 4'h0;
      end else begin
        strength_q[ch] <= held_d;
      end
    end
  end

  // analog settings, one cycle behind the state
  always_comb begin
    ctrl_d.boost         = first_q[rgs_pkg::FIRST_BOOST_BIT]; // R1
    ctrl_d.firstStageRed = first_q[2:0]; // R1
    ctrl_d.filter        = filter_q; // R2 R3
    if (gainState_q <= rgs_pkg::WINDOW_STEPS) begin
      ctrl_d.windowStep = gainState_q[2:0]; // R6 R7
      ctrl_d.stageRed   = 3'h0; // R4
    end else begin
      ctrl_d.windowStep = rgs_pkg::WINDOW_STEPS[2:0]; // R7
      ctrl_d.stageRed   = 3'(gainState_q - rgs_pkg::WINDOW_STEPS); // R4
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end
  assign rxCtrl = ctrl_q;

  // checks
  property p_gain_sat;
    gainState_q <= rgs_pkg::GAIN_LAST && squelchLevel_q <= rgs_pkg::GAIN_LAST;
  endproperty
  a_gain_sat: assert property (p_gain_sat) // R21
    else $error("gain state past last step");
  property p_map;
    ##1 (rxCtrl.windowStep + rxCtrl.stageRed == $past(gainState_q)) &&
    (rxCtrl.stageRed == 3'h0 || rxCtrl.windowStep == 3'h4);
  endproperty
  a_map: assert property (p_map) // R7
    else $error("gain state to window and gain mapping wrong");
  property p_capture;
    (rxOnPrev_q && !rxOn && !cmdResetGain) |=>
    capture_q == $past(gainState_q);
  endproperty
  a_capture: assert property (p_capture) // R8
    else $error("gain state not captured at receiver off");
  property p_idle_follow;
    $past(!rxOn) |-> gainState_q == squelchLevel_q;
  endproperty
  a_idle_follow: assert property (p_idle_follow) // R9
    else $error("gain loop not held in reset while off");
  property p_reset_cmd;
    cmdResetGain |=> squelchLevel_q == $past(manual_q) &&
    sqState_q == rgs_pkg::SQ_IDLE && strength_q == 8'h00;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) // R5
    else $error("reset gain command not applied");
  property p_clear;
    (cmdClear || agcStep) |=> strength_q == 8'h00;
  endproperty
  a_clear: assert property (p_clear) // R20
    else $error("signal strength not cleared");
  property p_freeze;
    (!rxOn && !clrStrength) |=> $stable(strength_q);
  endproperty
  a_freeze: assert property (p_freeze) // R17
    else $error("signal strength moved while off");
  property p_strength_max;
    strength_q[0] <= 4'hd && strength_q[1] <= 4'hd;
  endproperty
  a_strength_max: assert property (p_strength_max) // R19
    else $error("signal strength above thirteen");
  property p_sq_start;
    (sqState_q == rgs_pkg::SQ_OBSERVE &&
     $past(sqState_q) == rgs_pkg::SQ_WAIT) |->
    $past(delayCnt_q) == DLY_LAST_I;
  endproperty
  a_sq_start: assert property (p_sq_start) // R10
    else $error("squelch started at wrong delay");
  property p_sq_step;
    sqStep |-> winCnt_q == WIN_LAST &&
    (transCnt_q == 2'h3 || (transCnt_q == 2'h2 && sqTrans));
  endproperty
  a_sq_step: assert property (p_sq_step) // R12
    else $error("squelch stepped without enough transitions");
  property p_first_max;
    first_q[2:0] <= 3'h6;
  endproperty
  a_first_max: assert property (p_first_max) // R1
    else $error("first stage reduction beyond six steps");
  c_sq_step: cover property (sqStep);
  c_agc_step: cover property (agcStep);
  c_gain_max: cover property (gainState_q == rgs_pkg::GAIN_LAST && rxOn);
endmodule : rgs_rx_gain_ctrl
